// [verilog/limit_home_ctrl.v]
`timescale 1ns/1ps
`include "limit_home_regs.vh"
module limit_home_ctrl #(
    parameter PW = 16
) (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        ce,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output wire        pready,
    output reg  [31:0] prdata,
    output reg         pslverr,
    input  wire        limit_sw1,
    input  wire        limit_sw2,
    input  wire        rev_sensor,
    output wire        step_pulse,
    output reg         step_dir,
    output wire        motion_active,
    output wire        alarm,
    output wire        irq
);
    // Motion states
    localparam [2:0] ST_IDLE  = 3'd0;
    localparam [2:0] ST_MOVE  = 3'd1;
    localparam [2:0] ST_HOME1 = 3'd2;
    localparam [2:0] ST_HOME2 = 3'd3;
    localparam [2:0] ST_STAND = 3'd4;
    localparam [2:0] ST_ALARM = 3'd5;

    reg [`CTRL_WIDTH-1:0] ctrl_reg;
    reg [31:0]            target_reg;
    reg [31:0]            low_limit_reg;
    reg [31:0]            high_limit_reg;
    reg [PW-1:0]          work_period_reg;
    reg [PW-1:0]          home1_period_reg;
    reg [PW-1:0]          home2_period_reg;
    reg [31:0]            standoff_reg;
    reg [31:0]            position_reg;
    reg [2:0]             state_reg;
    reg [`IRQ_WIDTH-1:0]  irq_stat_reg;
    reg [`IRQ_WIDTH-1:0]  irq_mask_reg;
    reg                   acc_ok_reg;
    reg [2:0]             sw1_sync_reg;
    reg [2:0]             sw2_sync_reg;
    reg [2:0]             rev_sync_reg;
    reg                   low_act_d_reg;
    reg                   high_act_d_reg;

    // Signed compare used by both limit checks and the move target
    function at_or_below;
        input [31:0] a;
        input [31:0] b;
        begin
            at_or_below = ($signed(a) <= $signed(b));
        end
    endfunction

    // Register index decode, used by the read mux only; writes compare the full paddr
    function [3:0] reg_index;
        input [7:0] addr;
        begin
            reg_index = addr[5:2];
        end
    endfunction

    // Pins come from the stage, two flops before use; third flop for the rev_sensor edge
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sw1_sync_reg <= 3'h0;
            sw2_sync_reg <= 3'h0;
            rev_sync_reg <= 3'h0;
        end else if (ce) begin
            sw1_sync_reg <= {sw1_sync_reg[1:0], limit_sw1};
            sw2_sync_reg <= {sw2_sync_reg[1:0], limit_sw2};
            rev_sync_reg <= {rev_sync_reg[1:0], rev_sensor};
        end
    end

    // Polarity then end assignment
    wire sw1_act  = ~(sw1_sync_reg[1] ^ ctrl_reg[`CTRL_SW1_ACTIVE_HIGH]) ? 1'b1 : 1'b0;
    wire sw2_act  = ~(sw2_sync_reg[1] ^ ctrl_reg[`CTRL_SW2_ACTIVE_HIGH]) ? 1'b1 : 1'b0;
    wire swap     = ctrl_reg[`CTRL_SW_SWAP];
    wire low_act  = swap ? sw2_act : sw1_act;
    wire high_act = swap ? sw1_act : sw2_act;
    wire low_rise = low_act & ~low_act_d_reg;
    wire high_rise = high_act & ~high_act_d_reg;
    wire rev_rise = rev_sync_reg[1] & ~rev_sync_reg[2];

    wire by_switch = ctrl_reg[`CTRL_BOUND_BY_SWITCH];
    wire moving    = (state_reg == ST_MOVE) || (state_reg == ST_HOME1) ||
                     (state_reg == ST_HOME2) || (state_reg == ST_STAND);
    wire homing    = (state_reg == ST_HOME1) || (state_reg == ST_HOME2);

    // Direction for each motion state: 1 means right
    wire home_dir  = (state_reg == ST_HOME1) ? ctrl_reg[`CTRL_HOME1_DIR] : ctrl_reg[`CTRL_HOME2_DIR];
    wire stop_rev  = (state_reg == ST_HOME1) ? ctrl_reg[`CTRL_HOME1_STOP_REV] : ctrl_reg[`CTRL_HOME2_STOP_REV];
    wire tgt_dir   = ~at_or_below(target_reg, position_reg);
    wire run_dir   = homing ? home_dir : tgt_dir;
    wire at_target = (target_reg == position_reg);

    // Border halts; in homing the stop condition takes precedence over them
    wire halt_low  = by_switch && ctrl_reg[`CTRL_HALT_LOW] && !run_dir && low_act;
    wire halt_high = by_switch && ctrl_reg[`CTRL_HALT_HIGH] && run_dir && high_act;
    wire pos_low   = !by_switch && !homing && !run_dir &&
                     at_or_below(position_reg, low_limit_reg);
    wire pos_high  = !by_switch && !homing && run_dir &&
                     at_or_below(high_limit_reg, position_reg);

    // Only a fresh activation counts, so standoff off a held switch is safe
    wire misset    = ctrl_reg[`CTRL_MISSET_EN] && by_switch && moving &&
                     ((run_dir && low_rise) || (!run_dir && high_rise));
    wire home_stop = homing && (stop_rev ? rev_rise : (run_dir ? high_act : low_act));
    wire border    = moving && !home_stop && (halt_low || halt_high || pos_low || pos_high);

    // APB access decode
    wire       setup  = psel && !penable;
    wire       access = psel && penable && pready;
    wire       wr     = access && pwrite;
    wire [3:0] idx    = reg_index(paddr);
    wire       cmd_wr = wr && (paddr == `OFS_CMD);
    wire       cmd_move = cmd_wr && pwdata[`CMD_MOVE];
    wire       cmd_stop = cmd_wr && pwdata[`CMD_STOP];
    wire       cmd_home = cmd_wr && pwdata[`CMD_HOME];
    wire       cmd_zero = cmd_wr && pwdata[`CMD_ZERO];
    wire       cmd_clr  = cmd_wr && pwdata[`CMD_CLEAR_ALARM];

    // Step timing per phase; no step until step_dir has turned, so the stage never sees a stale direction
    wire [PW-1:0] cur_period = (state_reg == ST_HOME1) ? home1_period_reg :
                               (state_reg == ST_HOME2) ? home2_period_reg : work_period_reg;
    wire step_run = moving && !border && !misset && !home_stop && !cmd_stop && (step_dir == run_dir) &&
                    !((state_reg == ST_MOVE || state_reg == ST_STAND) && at_target);

    step_gen #(
        .PW     (PW)
    ) u_step_gen (
        .pclk    (pclk),
        .presetn (presetn),
        .ce      (ce),
        .run     (step_run),
        .period  (cur_period),
        .step    (step_pulse)
    );

    assign pready        = acc_ok_reg & ce;
    assign motion_active = moving;
    assign alarm         = (state_reg == ST_ALARM);
    assign irq           = |(irq_stat_reg & irq_mask_reg);

    // Events raised this cycle
    wire [`IRQ_WIDTH-1:0] events;
    assign events[`IRQ_LOW_HALT]  = border && (halt_low || pos_low);
    assign events[`IRQ_HIGH_HALT] = border && (halt_high || pos_high);
    assign events[`IRQ_MISSET]    = misset;
    assign events[`IRQ_HOME_DONE] = (state_reg == ST_STAND) && at_target;
    assign events[`IRQ_MOVE_DONE] = (state_reg == ST_MOVE) && at_target;

    // Motion state machine and position counter
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg      <= ST_IDLE;
            position_reg   <= 32'h0;
            step_dir       <= 1'b0;
            low_act_d_reg  <= 1'b0;
            high_act_d_reg <= 1'b0;
        end else if (ce) begin
            low_act_d_reg  <= low_act;
            high_act_d_reg <= high_act;
            step_dir       <= run_dir;
            if (step_pulse) begin
                position_reg <= run_dir ? position_reg + 32'h1 : position_reg - 32'h1;
            end
            case (state_reg)
                ST_IDLE: begin
                    if (cmd_zero) begin
                        position_reg <= 32'h0;
                    end else if (cmd_home) begin
                        state_reg <= ST_HOME1;
                    end else if (cmd_move) begin
                        state_reg <= ST_MOVE;
                    end
                end
                ST_MOVE: begin
                    if (misset && ctrl_reg[`CTRL_ALARM_ON_MISSET]) begin
                        state_reg <= ST_ALARM;
                    end else if (misset || border || cmd_stop || at_target) begin
                        state_reg <= ST_IDLE;
                    end
                end
                ST_HOME1, ST_HOME2: begin
                    if (misset && ctrl_reg[`CTRL_ALARM_ON_MISSET]) begin
                        state_reg <= ST_ALARM;
                    end else if (misset || cmd_stop) begin
                        state_reg <= ST_IDLE;
                    end else if (home_stop) begin
                        if (state_reg == ST_HOME1 && ctrl_reg[`CTRL_HOME2_EN]) begin
                            state_reg <= ST_HOME2;
                        end else begin
                            state_reg <= ST_STAND;
                        end
                    end else if (border) begin
                        state_reg <= ST_IDLE;
                    end
                end
                ST_STAND: begin
                    if (misset && ctrl_reg[`CTRL_ALARM_ON_MISSET]) begin
                        state_reg <= ST_ALARM;
                    end else if (misset || border || cmd_stop || at_target) begin
                        state_reg <= ST_IDLE;
                    end
                end
                ST_ALARM: begin
                    // Alarm holds off all motion until software clears it
                    if (cmd_clr) begin
                        state_reg <= ST_IDLE;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // Register file writes; target also loaded by homing for the standoff
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg         <= `CTRL_RESET;
            target_reg       <= 32'h0;
            low_limit_reg    <= `LOW_LIMIT_RESET;
            high_limit_reg   <= `HIGH_LIMIT_RESET;
            work_period_reg  <= `PERIOD_RESET;
            home1_period_reg <= `PERIOD_RESET;
            home2_period_reg <= `PERIOD_RESET;
            standoff_reg     <= 32'h0;
            irq_mask_reg     <= {`IRQ_WIDTH{1'b0}};
            irq_stat_reg     <= {`IRQ_WIDTH{1'b0}};
        end else if (ce) begin
            if (wr && paddr == `OFS_CTRL)         ctrl_reg <= pwdata[`CTRL_WIDTH-1:0];
            if (wr && paddr == `OFS_MOVE_TARGET)  target_reg <= pwdata;
            if (wr && paddr == `OFS_LOW_LIMIT)    low_limit_reg <= pwdata;
            if (wr && paddr == `OFS_HIGH_LIMIT)   high_limit_reg <= pwdata;
            if (wr && paddr == `OFS_WORK_PERIOD)  work_period_reg <= pwdata[PW-1:0];
            if (wr && paddr == `OFS_HOME1_PERIOD) home1_period_reg <= pwdata[PW-1:0];
            if (wr && paddr == `OFS_HOME2_PERIOD) home2_period_reg <= pwdata[PW-1:0];
            if (wr && paddr == `OFS_STANDOFF)     standoff_reg <= pwdata;
            if (wr && paddr == `OFS_IRQ_MASK)     irq_mask_reg <= pwdata[`IRQ_WIDTH-1:0];
            // Standoff target taken from the stop point; signed add covers both ways
            if (homing && home_stop && !misset && !cmd_stop &&
                !(state_reg == ST_HOME1 && ctrl_reg[`CTRL_HOME2_EN])) begin
                target_reg <= position_reg + standoff_reg;
            end
            // New events win over a write-one clear in the same cycle
            if (wr && paddr == `OFS_IRQ_STATUS) begin
                irq_stat_reg <= (irq_stat_reg & ~pwdata[`IRQ_WIDTH-1:0]) | events;
            end else begin
                irq_stat_reg <= irq_stat_reg | events;
            end
        end
    end

    // Read data captured in setup so the data output is a flop
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata     <= 32'h0;
            pslverr    <= 1'b0;
            acc_ok_reg <= 1'b0;
        end else if (ce) begin
            if (setup) begin
                acc_ok_reg <= 1'b1;
                pslverr    <= (paddr[1:0] != 2'b00) || (paddr > `OFS_IRQ_MASK);
                case (idx)
                    4'h0: prdata <= {{(32-`CTRL_WIDTH){1'b0}}, ctrl_reg};
                    4'h2: prdata <= target_reg;
                    4'h3: prdata <= low_limit_reg;
                    4'h4: prdata <= high_limit_reg;
                    4'h5: prdata <= {{(32-PW){1'b0}}, work_period_reg};
                    4'h6: prdata <= {{(32-PW){1'b0}}, home1_period_reg};
                    4'h7: prdata <= {{(32-PW){1'b0}}, home2_period_reg};
                    4'h8: prdata <= standoff_reg;
                    4'h9: prdata <= position_reg;
                    4'ha: prdata <= {24'h0, high_act, low_act, rev_sync_reg[1], step_dir, moving, state_reg};
                    4'hb: prdata <= {{(32-`IRQ_WIDTH){1'b0}}, irq_stat_reg};
                    4'hc: prdata <= {{(32-`IRQ_WIDTH){1'b0}}, irq_mask_reg};
                    default: prdata <= 32'h0;
                endcase
            end else if (access) begin
                acc_ok_reg <= 1'b0;
            end
        end
    end
endmodule // limit_home_ctrl

// [verilog/limit_home_regs.vh]
`ifndef LIMIT_HOME_REGS_VH
`define LIMIT_HOME_REGS_VH

// Register byte offsets
`define OFS_CTRL          8'h00
`define OFS_CMD           8'h04
`define OFS_MOVE_TARGET   8'h08
`define OFS_LOW_LIMIT     8'h0c
`define OFS_HIGH_LIMIT    8'h10
`define OFS_WORK_PERIOD   8'h14
`define OFS_HOME1_PERIOD  8'h18
`define OFS_HOME2_PERIOD  8'h1c
`define OFS_STANDOFF      8'h20
`define OFS_POSITION      8'h24
`define OFS_STATUS        8'h28
`define OFS_IRQ_STATUS    8'h2c
`define OFS_IRQ_MASK      8'h30

// Control register fields
`define CTRL_BOUND_BY_SWITCH  0
`define CTRL_SW1_ACTIVE_HIGH  1
`define CTRL_SW2_ACTIVE_HIGH  2
`define CTRL_HALT_LOW         3
`define CTRL_HALT_HIGH        4
`define CTRL_SW_SWAP          5
`define CTRL_MISSET_EN        6
`define CTRL_ALARM_ON_MISSET  7
`define CTRL_HOME1_DIR        8
`define CTRL_HOME1_STOP_REV   9
`define CTRL_HOME2_EN         10
`define CTRL_HOME2_DIR        11
`define CTRL_HOME2_STOP_REV   12
`define CTRL_WIDTH            13
`define CTRL_RESET            13'h0019

// Command register fields (write-only strobes)
`define CMD_MOVE         0
`define CMD_STOP         1
`define CMD_HOME         2
`define CMD_ZERO         3
`define CMD_CLEAR_ALARM  4

// Interrupt status fields
`define IRQ_LOW_HALT   0
`define IRQ_HIGH_HALT  1
`define IRQ_MISSET     2
`define IRQ_HOME_DONE  3
`define IRQ_MOVE_DONE  4
`define IRQ_WIDTH      5

// Reset values
`define PERIOD_RESET     16'h03e8
`define LOW_LIMIT_RESET  32'hfffffc18
`define HIGH_LIMIT_RESET 32'h000003e8

`endif

// [verilog/step_gen.v]
`timescale 1ns/1ps
module step_gen #(
    parameter PW = 16
) (
    input  wire          pclk,
    input  wire          presetn,
    input  wire          ce,
    input  wire          run,
    input  wire [PW-1:0] period,
    output wire          step
);
    reg [PW-1:0] cnt_reg;

    // One step each period cycles; zero period treated as one
    assign step = run && (cnt_reg + 1'b1 >= period);

    // Restart on every halt so a new motion begins with a full period
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg <= {PW{1'b0}};
        end else if (ce) begin
            if (!run || step) begin
                cnt_reg <= {PW{1'b0}};
            end else begin
                cnt_reg <= cnt_reg + 1'b1;
            end
        end
    end
endmodule // step_gen

// [verif/limit_home_props.sv]
`timescale 1ns/1ps
`include "limit_home_regs.vh"
module limit_home_props (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        ce,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        limit_sw1,
    input wire logic        limit_sw2,
    input wire logic        step_pulse,
    input wire logic        step_dir,
    input wire logic        motion_active,
    input wire logic        alarm
);
    logic [12:0] ctrl_q;
    logic        wr_done;
    logic        low_act;
    logic        high_act;

    // Shadow of the control word, taken only from completed writes
    assign wr_done = psel && penable && pready && pwrite;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            ctrl_q <= `CTRL_RESET;
        else if (wr_done && paddr == `OFS_CTRL)
            ctrl_q <= pwdata[12:0];
    end

    // Raw pins through polarity and end assignment; sync lag is covered by the repeats
    assign low_act  = ctrl_q[5] ? (limit_sw2 == ctrl_q[2]) : (limit_sw1 == ctrl_q[1]);
    assign high_act = ctrl_q[5] ? (limit_sw1 == ctrl_q[1]) : (limit_sw2 == ctrl_q[2]);

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_halt_low: assert property ((ctrl_q[0] && ctrl_q[3] && low_act && !step_dir)[*5] |-> !step_pulse)
        else $error("Step taken toward an active low end switch");
    a_halt_high: assert property ((ctrl_q[0] && ctrl_q[4] && high_act && step_dir)[*5] |-> !step_pulse)
        else $error("Step taken toward an active high end switch");
    a_misset_stop: assert property (ctrl_q[0] && ctrl_q[6] && !ctrl_q[7] && motion_active && step_dir
        && $rose(low_act) |-> ##[1:6] (!motion_active && !alarm)) else $error("Misset did not stop motion");
    a_misset_alarm: assert property (ctrl_q[0] && ctrl_q[6] && ctrl_q[7] && motion_active && step_dir
        && $rose(low_act) |-> ##[1:6] alarm) else $error("Misset did not raise the alarm");
    a_alarm_quiet: assert property (alarm |-> !motion_active && !step_pulse)
        else $error("Motion while in alarm");
    a_alarm_clear: assert property (alarm && wr_done && paddr == `OFS_CMD && pwdata[4] |=> !alarm)
        else $error("Alarm not cleared by command");
    a_idle_quiet: assert property (!motion_active [*2] |-> !step_pulse)
        else $error("Step pulse while halted");
    a_home_start: assert property (wr_done && paddr == `OFS_CMD && pwdata[2] && !pwdata[3] && !motion_active
        && !alarm && !low_act && !high_act |=> motion_active ##2 (step_dir == ctrl_q[8]))
        else $error("Homing did not start in its first direction");
    a_ready_access: assert property (psel && penable && ce |-> pready)
        else $error("Access phase not answered at once");
    a_bad_addr: assert property (psel && !penable && ce && (paddr > 8'h30 || paddr[1:0] != 2'b00) |=> pslverr)
        else $error("Unmapped address not refused");

    // Main scenarios
    c_alarm: cover property ($rose(alarm));
    c_home: cover property (wr_done && paddr == `OFS_CMD && pwdata[2]);
    c_halt: cover property ($fell(motion_active) && (low_act || high_act));
endmodule // limit_home_props

// [verif/stage_model.sv]
`timescale 1ns/1ps
module stage_model #(
    parameter int END_POS = 20,
    parameter int REV_GAP = 8
) (
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  wire logic          step_pulse,
    input  wire logic          step_dir,
    input  wire logic          crossed,
    output logic               limit_sw1,
    output logic               limit_sw2,
    output logic               rev_sensor,
    output logic signed [31:0] phys
);
    logic low_hit;
    logic high_hit;

    // One step per pulse, right is positive
    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            phys <= '0;
        else if (step_pulse)
            phys <= step_dir ? phys + 1 : phys - 1;
    end

    // Pressed switch pulls low; crossed cabling swaps the two ends
    assign low_hit    = phys <= -END_POS;
    assign high_hit   = phys >= END_POS;
    assign limit_sw1  = !(crossed ? high_hit : low_hit);
    assign limit_sw2  = !(crossed ? low_hit : high_hit);
    // Revolution mark every few steps
    assign rev_sensor = (phys % REV_GAP) == 0;
endmodule // stage_model

// [verif/limit_home_ctrl_tb.sv]
`timescale 1ns/1ps
`include "limit_home_regs.vh"
module limit_home_ctrl_tb;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic        crossed;
    logic [31:0] r;
    logic        err;
    wire         pready;
    wire  [31:0] prdata;
    wire         pslverr;
    wire         limit_sw1;
    wire         limit_sw2;
    wire         rev_sensor;
    wire         step_pulse;
    wire         step_dir;
    wire         motion_active;
    wire         alarm;
    wire         irq;
    wire  [31:0] phys;
    int          failures;
    int          n_tests;

    limit_home_ctrl #(.PW(16)) uut (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .limit_sw1(limit_sw1), .limit_sw2(limit_sw2), .rev_sensor(rev_sensor), .step_pulse(step_pulse),
        .step_dir(step_dir), .motion_active(motion_active), .alarm(alarm), .irq(irq));
    stage_model stage (.pclk(pclk), .presetn(presetn), .step_pulse(step_pulse), .step_dir(step_dir),
        .crossed(crossed), .limit_sw1(limit_sw1), .limit_sw2(limit_sw2), .rev_sensor(rev_sensor), .phys(phys));

    // Bus clock, 4 ns period
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    task chk(input logic [31:0] s, input logic [31:0] e);
        n_tests = n_tests + 1;
        if (s !== e) begin
            failures = failures + 1;
            $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask

    // One APB transfer; holds the request until pready is seen at an edge
    task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // pready is sampled at each rising edge; if it never comes, only the watchdog ends this wait
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        r = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(a, 1'b1, d);
    endtask

    task rd(input logic [7:0] a);
        apb(a, 1'b0, 32'h0);
    endtask

    // Issue a command and wait for motion to end
    task go(input logic [31:0] c);
        wr(`OFS_CMD, c);
        @(negedge pclk);
        while (motion_active !== 1'b0)
            @(negedge pclk);
    endtask

    task t_regs;
        rd(`OFS_CTRL);
        chk(r, {19'h0, `CTRL_RESET});
        rd(`OFS_LOW_LIMIT);
        chk(r, `LOW_LIMIT_RESET);
        rd(`OFS_HIGH_LIMIT);
        chk(r, `HIGH_LIMIT_RESET);
        rd(`OFS_HOME1_PERIOD);
        chk(r, {16'h0, `PERIOD_RESET});
        rd(`OFS_IRQ_MASK);
        chk(r, 32'h0);
        rd(8'h34);
        chk(r, 32'h0);
        chk(32'(err), 32'h1);
    endtask

    // Bounded by position: stops at the high limit
    task t_bound_pos;
        wr(`OFS_CTRL, 32'h18);
        wr(`OFS_HIGH_LIMIT, 32'ha);
        wr(`OFS_WORK_PERIOD, 32'h6);
        wr(`OFS_MOVE_TARGET, 32'hf);
        go(32'h1);
        rd(`OFS_POSITION);
        chk(r, 32'ha);
        chk(phys, 32'ha);
    endtask

    // Active-low switch halts travel; status, mask and clear of the interrupt
    task t_bound_sw;
        wr(`OFS_CTRL, 32'h19);
        wr(`OFS_MOVE_TARGET, 32'h32);
        go(32'h1);
        chk(phys, 32'h14);
        rd(`OFS_IRQ_STATUS);
        chk(r & 32'h2, 32'h2);
        wr(`OFS_IRQ_MASK, 32'h2);
        @(negedge pclk);
        chk(32'(irq), 32'h1);
        wr(`OFS_IRQ_STATUS, 32'h2);
        @(negedge pclk);
        chk(32'(irq), 32'h0);
        wr(`OFS_IRQ_MASK, 32'h0);
    endtask

    // Left homing with positive standoff, then two phases with negative standoff
    task t_home;
        wr(`OFS_HOME1_PERIOD, 32'ha);
        wr(`OFS_HOME2_PERIOD, 32'ha);
        wr(`OFS_STANDOFF, 32'h5);
        go(32'h4);
        chk(phys, 32'hfffffff1);
        rd(`OFS_IRQ_STATUS);
        chk(r & 32'h8, 32'h8);
        wr(`OFS_CTRL, 32'h1519);
        wr(`OFS_STANDOFF, 32'hfffffffd);
        go(32'h4);
        chk(phys, 32'hd);
    endtask

    // Zero, move off, home again: back at origin
    task t_zero;
        go(32'h8);
        rd(`OFS_POSITION);
        chk(r, 32'h0);
        wr(`OFS_MOVE_TARGET, 32'h5);
        go(32'h1);
        go(32'h4);
        rd(`OFS_POSITION);
        chk(r, 32'h0);
        chk(phys, 32'hd);
    endtask

    // Crossed cabling: stop-only misset, swap repair, then alarm
    task t_misset;
        @(posedge pclk);
        crossed <= 1'b1;
        wr(`OFS_CTRL, 32'h59);
        wr(`OFS_MOVE_TARGET, 32'h64);
        go(32'h1);
        chk(phys, 32'h14);
        chk(32'(alarm), 32'h0);
        rd(`OFS_IRQ_STATUS);
        chk(r & 32'h4, 32'h4);
        wr(`OFS_CTRL, 32'h39);
        wr(`OFS_MOVE_TARGET, 32'hffffff9c);
        go(32'h1);
        chk(phys, 32'hffffffec);
        wr(`OFS_CTRL, 32'hc1);
        wr(`OFS_MOVE_TARGET, 32'h64);
        go(32'h1);
        chk(32'(alarm), 32'h1);
        wr(`OFS_CMD, 32'h10);
        @(negedge pclk);
        chk(32'(alarm), 32'h0);
    endtask

    task results;
        if (failures == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // Main sequence
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        crossed = 1'b0;
        failures = 0;
        n_tests = 0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        t_regs;
        t_bound_pos;
        t_bound_sw;
        t_home;
        t_zero;
        t_misset;
        results;
    end

    // Watchdog well beyond the expected run of a few thousand cycles
    initial begin
        #200000;
        failures = failures + 1;
        results;
    end
endmodule // limit_home_ctrl_tb

bind limit_home_ctrl limit_home_props props_i (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .limit_sw1(limit_sw1), .limit_sw2(limit_sw2), .step_pulse(step_pulse), .step_dir(step_dir),
    .motion_active(motion_active), .alarm(alarm));
